/* src/atc_pkg.sv */
// What this block does
// - Task reset bit holds card in reset
// - Mask bit one suppresses interrupt request
// - Echo bits 5..2 read inverted head field
// - E5H and 98H check power mode
// - 90H runs internal diagnostics
// - C0H erases addressed sectors, block mode allowed
// - 50H takes one sector, data unchanged
// - ECH returns parameter information as data
// - Only valid parameters are read per command
// - 40H and 41H verify sectors
// - CDH multi-sector write without erase
// - 38H sector write without erase
// - Block addressing accepted where supported
// - Busy reads alone while operation runs
// - Sector count zero means 256 sectors where the count is valid; 50H, ECH and commands without a count take one
package atc_pkg;
    // Register addresses on the plain port
    localparam logic [3:0] ADR_DATA = 4'h0;
    localparam logic [3:0] ADR_FEATURE = 4'h1;
    localparam logic [3:0] ADR_COUNT = 4'h2;
    localparam logic [3:0] ADR_INDEX = 4'h3;
    localparam logic [3:0] ADR_TRACK_LO = 4'h4;
    localparam logic [3:0] ADR_TRACK_HI = 4'h5;
    localparam logic [3:0] ADR_UNIT_HEAD = 4'h6;
    localparam logic [3:0] ADR_CMD_STATUS = 4'h7;
    localparam logic [3:0] ADR_CONTROL = 4'hE;
    localparam logic [3:0] ADR_ECHO = 4'hF;
    // Control and unit/head field positions
    localparam int CTL_RESET_POS = 2;
    localparam int CTL_MASK_POS = 1;
    localparam int UH_UNIT_POS = 4;
    localparam int UH_LBA_POS = 6;
    // Parameter-valid mask bit positions
    localparam int PV_FR = 6;
    localparam int PV_SC = 5;
    localparam int PV_SN = 4;
    localparam int PV_CY = 3;
    localparam int PV_DR = 2;
    localparam int PV_HD = 1;
    localparam int PV_LBA = 0;
    // Reset and returned values
    localparam logic [7:0] DEF_COUNT = 8'h01;
    localparam logic [7:0] DEF_INDEX = 8'h01;
    localparam logic [7:0] DEF_UNIT_HEAD = 8'hA0;
    localparam logic [7:0] POWER_ACTIVE = 8'hFF;
    localparam logic [7:0] DIAG_PASS = 8'h01;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] STATUS_BUSY = 8'h80;
    localparam logic [8:0] SECTOR_LAST_BYTE = 9'h1FF;
    localparam logic [8:0] FULL_SECTORS = 9'h100;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int CMD_BUSY_NS = 50;
    localparam int CMD_BUSY_CYC = (CMD_BUSY_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        ATC_K_NODATA = 3'b000,
        ATC_K_READ = 3'b001,
        ATC_K_WRITE = 3'b010,
        ATC_K_IDENT = 3'b011,
        ATC_K_FORMAT = 3'b100,
        ATC_K_BAD = 3'b101
    } atc_kind_t;
    typedef enum logic [2:0] {
        ATC_S_IDLE = 3'b000,
        ATC_S_BUSY = 3'b001,
        ATC_S_XIN = 3'b010,
        ATC_S_XOUT = 3'b011,
        ATC_S_RESET = 3'b100
    } atc_state_t;
endpackage

/* src/atc_opdec.sv */
`timescale 1ns/10ps
`default_nettype none
module atc_opdec (
    input wire logic [7:0] opcode, // Command code
    output var atc_pkg::atc_kind_t kind, // Command class
    output logic [6:0] pvalid // Valid parameter mask
);
    import atc_pkg::*;
    localparam logic [6:0] M_DR = 7'h04;
    localparam logic [6:0] M_ADDR = 7'h3F;
    localparam logic [6:0] M_FMT = 7'h2F;
    always_comb begin
        kind = ATC_K_BAD;
        pvalid = 7'h00;
        unique casez (opcode)
            8'hE5, 8'h98, 8'h90, 8'hE1, 8'h95, 8'hE6, 8'h99, 8'hE2, 8'h96,
            8'hE0, 8'h94, 8'h03, 8'b0001_????: begin
                kind = ATC_K_NODATA;
                pvalid = M_DR;
            end
            8'hC0, 8'h40, 8'h41, 8'h87, 8'b0111_????: begin
                kind = ATC_K_NODATA;
                pvalid = M_ADDR;
            end
            8'hE3, 8'h97, 8'hC6: begin
                kind = ATC_K_NODATA;
                pvalid = 7'h24;
            end
            8'h91: begin
                kind = ATC_K_NODATA;
                pvalid = 7'h26;
            end
            8'hF5: begin
                kind = ATC_K_NODATA;
                pvalid = 7'h06;
            end
            8'hEF: begin
                kind = ATC_K_NODATA;
                pvalid = 7'h44;
            end
            8'h50: begin
                kind = ATC_K_FORMAT;
                pvalid = M_FMT;
            end
            8'hEC: begin
                kind = ATC_K_IDENT;
                pvalid = M_DR;
            end
            8'hE4: begin
                kind = ATC_K_READ;
                pvalid = M_DR;
            end
            8'hE8: begin
                kind = ATC_K_WRITE;
                pvalid = M_DR;
            end
            8'hC4, 8'h20, 8'h21, 8'h22, 8'h23: begin
                kind = ATC_K_READ;
                pvalid = M_ADDR;
            end
            8'hC5, 8'hCD, 8'h30, 8'h31, 8'h38, 8'h3C, 8'h32, 8'h33: begin
                kind = ATC_K_WRITE;
                pvalid = M_ADDR;
            end
            default: begin
                kind = ATC_K_BAD;
                pvalid = 7'h00;
            end
        endcase
    end
endmodule // atc_opdec
`default_nettype wire

/* src/atc_sector_ram.sv */
`timescale 1ns/10ps
`default_nettype none
module atc_sector_ram (
    input wire logic core_clk, // Clock
    input wire logic wr_en, // Write enable
    input wire logic [8:0] wr_addr, // Write byte address
    input wire logic [7:0] wr_data, // Write byte
    input wire logic [8:0] rd_addr, // Read byte address
    output logic [7:0] rd_q // Registered read byte
);
    logic [7:0] mem [0:511];
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_q <= mem[rd_addr];
    end
endmodule // atc_sector_ram
`default_nettype wire

/* src/atc_task_file.sv */
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module atc_task_file (
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [3:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output logic card_int_request_n // Interrupt request, low active
);
    import atc_pkg::*;

    atc_state_t state;
    logic [7:0] feature_reg;
    logic [7:0] sector_count_reg;
    logic [7:0] sector_index_reg;
    logic [15:0] track_group_reg;
    logic [7:0] unit_head;
    logic [7:0] error_reg;
    logic err_flag;
    logic xfer_request_flag;
    logic int_pend;
    logic task_reset_bit;
    logic irq_mask_bit;
    logic [7:0] cur_cmd;
    atc_kind_t cur_kind;
    logic [6:0] cur_valid;
    logic [8:0] sectors_left;
    logic [8:0] byte_idx;
    logic [7:0] busy_cnt;
    logic [7:0] ident_q;
    logic [7:0] feat_seen;

    // Address decode
    wire wr_cmd = reg_wr && reg_addr == ADR_CMD_STATUS;
    wire wr_ctl = reg_wr && reg_addr == ADR_CONTROL;
    wire wr_data = reg_wr && reg_addr == ADR_DATA;
    wire rd_data = reg_rd && reg_addr == ADR_DATA;
    wire rd_status = reg_rd && reg_addr == ADR_CMD_STATUS;
    wire idle = state == ATC_S_IDLE;
    wire in_reset = state == ATC_S_RESET;
    wire param_wr = reg_wr && idle && !task_reset_bit;

    atc_kind_t dec_kind;
    logic [6:0] dec_valid;
    atc_opdec u_dec (
        .opcode(reg_wdata),
        .kind(dec_kind),
        .pvalid(dec_valid)
    );
    // Commands land only when ready; others are dropped
    wire cmd_go = wr_cmd && idle && !task_reset_bit;

    // Byte stream through the sector buffer
    wire rd_step = rd_data && state == ATC_S_XIN;
    wire wr_step = wr_data && state == ATC_S_XOUT;
    wire byte_step = rd_step || wr_step;
    wire last_byte = byte_idx == SECTOR_LAST_BYTE;
    wire sector_done = byte_step && last_byte;
    wire final_sector = sectors_left == 9'h001;
    wire [8:0] next_byte_idx = byte_step ? byte_idx + 9'h001 : byte_idx;
    // Format keeps the buffer untouched
    wire ram_we = wr_step && cur_kind == ATC_K_WRITE;
    logic [7:0] ram_q;
    atc_sector_ram u_ram (
        .core_clk(core_clk),
        .wr_en(ram_we),
        .wr_addr(byte_idx),
        .wr_data(reg_wdata),
        .rd_addr(next_byte_idx),
        .rd_q(ram_q)
    );

    // Parameter block, one 16-bit word per identify word, low byte first
    wire [7:0] id_word = next_byte_idx[8:1];
    logic [15:0] id_val;
    always_comb begin
        unique case (id_word)
            8'd0: id_val = 16'h848A;
            8'd1: id_val = 16'h0400;
            8'd3: id_val = 16'h0004;
            8'd6: id_val = 16'h0020;
            8'd8, 8'd60: id_val = 16'h8000;
            8'd20, 8'd21: id_val = 16'h0002;
            8'd22: id_val = 16'h0004;
            8'd47: id_val = 16'h0001;
            8'd49: id_val = 16'h0200;
            8'd51: id_val = 16'h0100;
            8'd59: id_val = 16'h0101;
            default: id_val = 16'h0000;
        endcase
    end
    wire [7:0] id_byte = next_byte_idx[0] ? id_val[15:8] : id_val[7:0];
    wire [7:0] data_out = cur_kind == ATC_K_IDENT ? ident_q : ram_q;

    // Busy hides the rest of the status byte
    wire [7:0] status_val = (state == ATC_S_BUSY || in_reset) ? STATUS_BUSY :
        {1'b0, 1'b1, 1'b0, 1'b1, xfer_request_flag, 2'b00, err_flag};
    // Only the head echo is defined; flags follow activity for show
    wire [7:0] echo_val = {1'b0, ~(state == ATC_S_XOUT), ~unit_head[3:0],
        ~unit_head[UH_UNIT_POS], unit_head[UH_UNIT_POS]};
    logic [7:0] next_rdata;
    always_comb begin
        unique case (reg_addr)
            ADR_DATA: next_rdata = data_out;
            ADR_FEATURE: next_rdata = error_reg;
            ADR_COUNT: next_rdata = sector_count_reg;
            ADR_INDEX: next_rdata = sector_index_reg;
            ADR_TRACK_LO: next_rdata = track_group_reg[7:0];
            ADR_TRACK_HI: next_rdata = track_group_reg[15:8];
            ADR_UNIT_HEAD: next_rdata = unit_head;
            ADR_CMD_STATUS: next_rdata = status_val;
            ADR_ECHO: next_rdata = echo_val;
            default: next_rdata = 8'h00;
        endcase
    end

    // Parameters outside the valid mask read as zero to the engine, apart from the count
    // Commands without a count move exactly one sector
    wire [8:0] eff_count = cur_valid[PV_SC] ? {1'b0, sector_count_reg} : 9'h001;
    wire [8:0] load_sectors = eff_count == 9'h000 ? FULL_SECTORS : eff_count;
    wire lba_mode = cur_valid[PV_LBA] && unit_head[UH_LBA_POS];
    wire busy_over = busy_cnt == 8'h00;
    wire done_evt = (state == ATC_S_BUSY && busy_over &&
        (cur_kind == ATC_K_NODATA || cur_kind == ATC_K_BAD)) || (sector_done && final_sector);
    wire drq_evt = state == ATC_S_BUSY && busy_over &&
        (cur_kind == ATC_K_READ || cur_kind == ATC_K_IDENT);
    wire next_sector_evt = sector_done && !final_sector && state == ATC_S_XIN;
    wire int_set = done_evt || drq_evt || next_sector_evt;
    wire int_clr = rd_status || cmd_go;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            task_reset_bit <= 1'b0;
            irq_mask_bit <= 1'b0;
        end else if (wr_ctl) begin
            task_reset_bit <= reg_wdata[CTL_RESET_POS];
            irq_mask_bit <= reg_wdata[CTL_MASK_POS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= ATC_S_IDLE;
            busy_cnt <= 8'h00;
            cur_cmd <= 8'h00;
            cur_kind <= ATC_K_NODATA;
            cur_valid <= 7'h00;
            sectors_left <= 9'h000;
            byte_idx <= 9'h000;
            xfer_request_flag <= 1'b0;
            err_flag <= 1'b0;
        end else if (task_reset_bit) begin
            state <= ATC_S_RESET;
            byte_idx <= 9'h000;
            xfer_request_flag <= 1'b0;
            err_flag <= 1'b0;
        end else begin
            byte_idx <= sector_done ? 9'h000 : next_byte_idx;
            unique case (state)
                ATC_S_RESET: state <= ATC_S_IDLE;
                ATC_S_IDLE: if (cmd_go) begin
                    state <= ATC_S_BUSY;
                    busy_cnt <= 8'(CMD_BUSY_CYC - 1);
                    cur_cmd <= reg_wdata;
                    cur_kind <= dec_kind;
                    cur_valid <= dec_valid;
                    err_flag <= 1'b0;
                    xfer_request_flag <= 1'b0;
                    byte_idx <= 9'h000;
                end
                ATC_S_BUSY: if (busy_over) begin
                    sectors_left <= (cur_kind == ATC_K_IDENT || cur_kind == ATC_K_FORMAT) ? 9'h001
                        : load_sectors;
                    unique case (cur_kind)
                        ATC_K_READ, ATC_K_IDENT: begin
                            state <= ATC_S_XIN;
                            xfer_request_flag <= 1'b1;
                        end
                        ATC_K_WRITE, ATC_K_FORMAT: begin
                            state <= ATC_S_XOUT;
                            xfer_request_flag <= 1'b1;
                        end
                        ATC_K_BAD: begin
                            state <= ATC_S_IDLE;
                            err_flag <= 1'b1;
                        end
                        default: state <= ATC_S_IDLE;
                    endcase
                end else begin
                    busy_cnt <= busy_cnt - 8'h01;
                end
                ATC_S_XIN, ATC_S_XOUT: if (sector_done) begin
                    sectors_left <= sectors_left - 9'h001;
                    if (final_sector) begin
                        state <= ATC_S_IDLE;
                        xfer_request_flag <= 1'b0;
                    end
                end
                default: state <= ATC_S_IDLE;
            endcase
        end
    end

    // Task file parameters
    always_ff @(posedge core_clk) begin
        if (rst || in_reset) begin
            feature_reg <= 8'h00;
            sector_count_reg <= DEF_COUNT;
            sector_index_reg <= DEF_INDEX;
            track_group_reg <= 16'h0000;
            unit_head <= DEF_UNIT_HEAD;
            error_reg <= in_reset ? DIAG_PASS : 8'h00;
            feat_seen <= 8'h00;
        end else if (state == ATC_S_BUSY && busy_over) begin
            if (cur_kind == ATC_K_BAD) begin
                error_reg <= ERR_ABORT;
            end else if (cur_cmd == 8'hE5 || cur_cmd == 8'h98) begin
                sector_count_reg <= POWER_ACTIVE;
            end else if (cur_cmd == 8'h90) begin
                error_reg <= DIAG_PASS;
            end else if (cur_cmd == 8'hF5) begin
                sector_count_reg <= 8'h00;
            end else if (cur_cmd == 8'hEF && cur_valid[PV_FR]) begin
                feat_seen <= feature_reg;
            end
        end else if (cmd_go) begin
            error_reg <= 8'h00;
        end else if (param_wr) begin
            unique case (reg_addr)
                ADR_FEATURE: feature_reg <= reg_wdata;
                ADR_COUNT: sector_count_reg <= reg_wdata;
                ADR_INDEX: sector_index_reg <= reg_wdata;
                ADR_TRACK_LO: track_group_reg[7:0] <= reg_wdata;
                ADR_TRACK_HI: track_group_reg[15:8] <= reg_wdata;
                ADR_UNIT_HEAD: unit_head <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Interrupt: set wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst || task_reset_bit) begin
            int_pend <= 1'b0;
            card_int_request_n <= 1'b1;
        end else begin
            int_pend <= int_set || (int_pend && !int_clr);
            card_int_request_n <= !(int_pend && !int_clr && !irq_mask_bit);
        end
    end

    // Read port stays alive in task reset so busy can be polled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            ident_q <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            ident_q <= id_byte;
        end
    end

    // Checks
    property p_irq_masked;
        @(posedge core_clk) disable iff (rst) irq_mask_bit |=> card_int_request_n;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq asserted while masked");

    property p_echo;
        @(posedge core_clk) disable iff (rst)
            (reg_rd && reg_addr == ADR_ECHO) |=> reg_rdata[5:2] == ~$past(unit_head[3:0]);
    endproperty
    a_echo: assert property (p_echo) else $error("head echo not inverted");

    property p_busy_status;
        @(posedge core_clk) disable iff (rst)
            (rd_status && state == ATC_S_BUSY) |=> reg_rdata == STATUS_BUSY;
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("busy status not alone");

    property p_reset_hold;
        @(posedge core_clk) disable iff (rst) task_reset_bit |=> state == ATC_S_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("left reset early");

    property p_defaults;
        @(posedge core_clk) disable iff (rst)
            (in_reset && !task_reset_bit) |=> (idle && sector_count_reg == DEF_COUNT && unit_head == DEF_UNIT_HEAD);
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not restored");

    sequence s_bad_cmd;
        cmd_go && dec_kind == ATC_K_BAD;
    endsequence
    property p_bad_cmd;
        @(posedge core_clk) disable iff (rst || task_reset_bit)
            s_bad_cmd |=> (state == ATC_S_BUSY && !err_flag) ##[1:20] (idle && err_flag && error_reg == ERR_ABORT);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad opcode not rejected");

    sequence s_read_zero;
        cmd_go && (dec_kind == ATC_K_READ || dec_kind == ATC_K_WRITE) && dec_valid[PV_SC] &&
            sector_count_reg == 8'h00;
    endsequence
    property p_zero_count;
        @(posedge core_clk) disable iff (rst || task_reset_bit)
            s_read_zero |=> ##[1:20] ((state == ATC_S_XIN || state == ATC_S_XOUT) && sectors_left == FULL_SECTORS);
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count not 256");

    property p_verify_no_drq;
        @(posedge core_clk) disable iff (rst || task_reset_bit)
            (cmd_go && reg_wdata == 8'h40) |=> (!xfer_request_flag)[*8];
    endproperty
    a_verify_no_drq: assert property (p_verify_no_drq) else $error("verify raised data request");

    property p_power;
        @(posedge core_clk) disable iff (rst || task_reset_bit)
            (cmd_go && reg_wdata == 8'hE5) |=> ##[1:20] (idle && sector_count_reg == POWER_ACTIVE);
    endproperty
    a_power: assert property (p_power) else $error("power mode not reported");

    property p_format_keep;
        @(posedge core_clk) disable iff (rst) (state == ATC_S_XOUT && cur_kind == ATC_K_FORMAT) |-> !ram_we;
    endproperty
    a_format_keep: assert property (p_format_keep) else $error("format wrote buffer");

    sequence s_no_count;
        cmd_go && (dec_kind == ATC_K_READ || dec_kind == ATC_K_WRITE) && !dec_valid[PV_SC];
    endsequence
    property p_no_count;
        @(posedge core_clk) disable iff (rst || task_reset_bit)
            s_no_count |=> ##[1:20] ((state == ATC_S_XIN || state == ATC_S_XOUT) && sectors_left == 9'h001);
    endproperty
    a_no_count: assert property (p_no_count) else $error("ignored count was used");

    property p_reset_quiet;
        @(posedge core_clk) disable iff (rst) task_reset_bit |=> (card_int_request_n && status_val == STATUS_BUSY);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("task reset not quiet");

    property p_reset_status;
        @(posedge core_clk) disable iff (rst) (rd_status && in_reset) |=> reg_rdata == STATUS_BUSY;
    endproperty
    a_reset_status: assert property (p_reset_status) else $error("busy not readable in reset");

    wire unused_ok = lba_mode ^ (|feat_seen) ^ (|cur_valid[PV_HD:PV_DR]);
endmodule // atc_task_file
`default_nettype wire

/* bench/atc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module atc_host_model (
    input wire logic core_clk, // Clock
    output logic [3:0] reg_addr, // Register address
    output logic [7:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata // Read data
);
    import atc_pkg::*;
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Released data bus flips so nothing leans on a stale byte
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic ctl(input logic rst_bit, input logic mask);
        wr(ADR_CONTROL, {4'h0, 1'b1, rst_bit, mask, 1'b0});
    endtask
    // Parameters always go ahead of the command code
    task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] uh);
        wr(ADR_COUNT, cnt);
        wr(ADR_INDEX, 8'h01);
        wr(ADR_TRACK_LO, 8'h00);
        wr(ADR_TRACK_HI, 8'h00);
        wr(ADR_UNIT_HEAD, uh);
        wr(ADR_CMD_STATUS, op);
    endtask
endmodule // atc_host_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import atc_pkg::*;
    logic core_clk;
    logic rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic card_int_request_n;
    logic [7:0] d;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    atc_task_file u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_int_request_n(card_int_request_n));
    atc_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string msg);
        u_host.rd(a, d);
        check(d, exp, msg);
    endtask
    task automatic irq(input logic exp, input string msg);
        check({7'h00, card_int_request_n}, {7'h00, exp}, msg);
    endtask
    // Busy time is fixed, so a fixed wait is enough; the status read drops the request
    task automatic done(input logic [7:0] st, input logic int_n);
        repeat (CMD_BUSY_CYC + 4) @(posedge core_clk);
        #1;
        irq(int_n, "int at end");
        rchk(ADR_CMD_STATUS, st, "end status");
        @(posedge core_clk);
        #1;
        irq(1'b1, "int after status");
    endtask
    task automatic xfer(input logic wr, input logic chk, input logic [7:0] seed, input int n);
        for (int i = 0; i < n; i++) begin
            if (wr) u_host.wr(ADR_DATA, 8'(i) ^ seed);
            else begin
                u_host.rd(ADR_DATA, d);
                if (chk) check(d, 8'(i) ^ seed, "buffer byte");
            end
        end
    endtask
    // Only data-in commands interrupt on the first request
    task automatic start_xfer(input logic [7:0] op, input logic [7:0] cnt, input logic int_n);
        u_host.cmd(op, cnt, DEF_UNIT_HEAD);
        rchk(ADR_CMD_STATUS, STATUS_BUSY, "busy");
        done(8'h58, int_n);
    endtask
    task automatic t_defaults;
        irq(1'b1, "int idle");
        rchk(ADR_COUNT, DEF_COUNT, "count");
        rchk(ADR_INDEX, DEF_INDEX, "index");
        rchk(ADR_UNIT_HEAD, DEF_UNIT_HEAD, "unit head");
        rchk(ADR_CONTROL, 8'h00, "control");
        rchk(4'h9, 8'h00, "unmapped");
        $display("defaults test done");
    endtask
    task automatic t_echo;
        for (int h = 0; h < 4; h++) begin
            u_host.wr(ADR_UNIT_HEAD, 8'hA0 | 8'(h));
            u_host.rd(ADR_ECHO, d);
            check(d & 8'h3C, {2'b00, ~4'(h), 2'b00}, "echo");
        end
        $display("echo test done");
    endtask
    task automatic t_nodata;
        logic [7:0] ops [8] = '{8'hE5, 8'h98, 8'h90, 8'hC0, 8'h40, 8'h41, 8'hF5, 8'h00};
        u_host.wr(ADR_FEATURE, 8'h5A);
        foreach (ops[k]) begin
            u_host.cmd(ops[k], (ops[k] == 8'hF5) ? 8'h07 : 8'h00, (ops[k] == 8'hC0) ? 8'hE3 : 8'hA3);
            done((ops[k] == 8'h00) ? 8'h51 : 8'h50, 1'b0);
            if (ops[k] inside {8'hE5, 8'h98}) rchk(ADR_COUNT, POWER_ACTIVE, "power");
            if (ops[k] == 8'h90) rchk(ADR_FEATURE, DIAG_PASS, "diag");
            if (ops[k] == 8'hF5) rchk(ADR_COUNT, 8'h00, "wear");
            if (ops[k] == 8'h00) rchk(ADR_FEATURE, ERR_ABORT, "abort");
        end
        u_host.ctl(1'b0, 1'b1);
        u_host.cmd(8'hE5, 8'h01, DEF_UNIT_HEAD);
        done(8'h50, 1'b1);
        u_host.ctl(1'b0, 1'b0);
        $display("nodata test done");
    endtask
    task automatic t_sectors;
        logic [7:0] ops [2] = '{8'h38, 8'hCD};
        foreach (ops[k]) begin
            start_xfer(ops[k], 8'h01, 1'b1);
            xfer(1'b1, 1'b0, 8'h11, 512);
            done(8'h50, 1'b0);
        end
        start_xfer(8'hE8, 8'h00, 1'b1);
        xfer(1'b1, 1'b0, 8'hA5, 512);
        done(8'h50, 1'b0);
        start_xfer(8'h50, 8'h01, 1'b1);
        xfer(1'b1, 1'b0, 8'h3C, 512);
        done(8'h50, 1'b0);
        start_xfer(8'hE4, 8'h00, 1'b0);
        xfer(1'b0, 1'b1, 8'hA5, 512);
        done(8'h50, 1'b0);
        start_xfer(8'hEC, 8'h00, 1'b0);
        rchk(ADR_DATA, 8'h8A, "ident lo");
        rchk(ADR_DATA, 8'h84, "ident hi");
        xfer(1'b0, 1'b0, 8'h00, 510);
        done(8'h50, 1'b0);
        $display("sector test done");
    endtask
    task automatic t_reset;
        start_xfer(8'h38, 8'h00, 1'b1);
        xfer(1'b1, 1'b0, 8'h22, 512);
        repeat (CMD_BUSY_CYC + 4) @(posedge core_clk);
        rchk(ADR_CMD_STATUS, 8'h58, "next sector");
        u_host.ctl(1'b1, 1'b0);
        rchk(ADR_CMD_STATUS, STATUS_BUSY, "in reset");
        irq(1'b1, "int in reset");
        u_host.wr(ADR_COUNT, 8'h55);
        u_host.ctl(1'b0, 1'b0);
        rchk(ADR_COUNT, DEF_COUNT, "count after");
        rchk(ADR_UNIT_HEAD, DEF_UNIT_HEAD, "uh after");
        u_host.rd(ADR_CMD_STATUS, d);
        check(d & 8'hC8, 8'h40, "ready after");
        $display("reset test done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Run needs about 8000 cycles; ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        rst = 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_defaults();
        t_echo();
        t_nodata();
        t_sectors();
        t_reset();
        finish_test();
    end
endmodule // tb
`default_nettype wire
